// *** tmz_params.svh ***
// constants for the timer/counter with shared divider
`ifndef TMZ_PARAMS_SVH
`define TMZ_PARAMS_SVH
// register offsets
`define TMZ_OFF_COUNT      8'h01
`define TMZ_OFF_INTCTL     8'h0b
`define TMZ_OFF_OPTION     8'h81
`define TMZ_OFF_PORTA_DIR  8'h85
`define TMZ_OFF_WDT_STAT   8'h90
`define TMZ_OFF_IRQ_STAT   8'h91
`define TMZ_OFF_IRQ_EN     8'h92
`define TMZ_OFF_IRQ_CLR    8'h93
// option field positions
`define TMZ_OPT_CS         5
`define TMZ_OPT_SE         4
`define TMZ_OPT_PSA        3
// interrupt control field positions
`define TMZ_INT_OVF_EN     5
`define TMZ_INT_OVF_FLAG   2
// reset values
`define TMZ_OPTION_RST     8'hff
`define TMZ_PORTA_RST      8'hff
`define TMZ_INTCTL_RST     8'h00
// instruction cycle is four core clocks (Q1..Q4)
`define TMZ_QPHASES        4
`define TMZ_INHIBIT_CYC    2
// status bits
`define TMZ_IRQ_OVF        0
`define TMZ_IRQ_WDT        1
`endif

// *** tmz_pkg.sv ***
// types for the timer/counter with shared divider
package tmz_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmz_bus_t;
   typedef enum logic {TMZ_OWNER_TIMER, TMZ_OWNER_WDT} tmz_owner_t;
endpackage

// *** tmz_divider.sv ***
// shared 8-bit divide counter with rate tap
`timescale 1ns/1ps
`include "tmz_params.svh"
module tmz_divider
   import tmz_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       clear,
   input  wire logic       tick,
   input  wire logic [2:0] rate,
   input  wire tmz_owner_t owner,
   output logic            out_pulse
);
   logic [WIDTH-1:0] div_reg;
   logic [WIDTH-1:0] div_next;
   logic [WIDTH-1:0] tap_mask;
   logic [2:0]       wdt_rate;

   // watchdog taps one stage lower: code 000 gives 1:1
   // rate code picks the tap
   assign wdt_rate = rate;
   assign tap_mask = (owner == TMZ_OWNER_TIMER) ?
                     WIDTH'((9'h002 << rate) - 9'h001) :
                     WIDTH'((9'h001 << wdt_rate) - 9'h001);
   assign div_next = clear ? '0 : (tick ? div_reg + 1'b1 : div_reg);

   // pulse when all low bits up to the tap are ones on a tick
   assign out_pulse = tick && !clear && ((div_reg & tap_mask) == tap_mask);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end
endmodule

// *** tmz_timer0.sv ***
// 8-bit timer/counter with prescaler shared with the watchdog
// ----------------------------------------------------------
// Notes on behaviour
// - clock source bit clear counts instruction cycles, set counts pin transitions.
// - edge bit set counts falling pin edges, clear counts rising edges.
// - assignment bit set gives the divider to the watchdog, clear to the timer.
// - rate code picks timer 1:2..1:256 or watchdog 1:1..1:128, doubling per code.
// - exactly one 8-bit divide counter serves either the timer or the watchdog.
// - the divide counter is never readable nor directly writable.
// - with the divider on the timer, any count write clears the divider.
// - with the divider on the watchdog, the watchdog clear resets divider and watchdog.
// - unprescaled timer mode advances per instruction cycle; a count write inhibits two cycles.
// - FFh to 00h sets the overflow flag; it interrupts only when enabled; software clears it.
// - counting stops during sleep.
// - the pin is synchronised and sampled at the Q2 and Q4 phases.
// ----------------------------------------------------------
`timescale 1ns/1ps
`include "tmz_params.svh"
module tmz_timer0
   import tmz_pkg::*;
#(
   parameter int WDT_WIDTH = 8
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   input  wire logic       external_count_pin,
   input  wire logic       sleep_mode,
   input  wire logic       watchdog_clear_instruction,
   output logic            watchdog_timeout,
   output logic            irq
);
   tmz_bus_t bus;
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   // 0x01 count value, read and write
   //      a write also clears the divider while the timer owns it
   //      a write holds off counting for two instruction ticks
   // 0x0b interrupt control
   //      bit 5 overflow interrupt enable
   //      bit 2 overflow flag, set by hardware, cleared by software
   //      other bits plain storage
   // 0x81 option control, resets to all ones
   //      bit 5 clock source select, 1 = pin
   //      bit 4 source edge select, 1 = falling
   //      bit 3 divider assignment, 1 = watchdog
   //      bits 2..0 rate select
   // 0x85 port a direction, plain storage, resets to all ones
   // 0x90 watchdog status, bit 0 timeout, read only
   // 0x91 interrupt status, sticky, read only
   //      bit 0 overflow, bit 1 watchdog wrap
   // 0x92 interrupt enable, same layout as the status
   // 0x93 interrupt clear, write one to clear, reads zero
   // the divider has no address at all, by intent

   // ----------------------------------------------------------
   // timing notes
   // ----------------------------------------------------------
   // one instruction cycle is four core clocks
   // the phase counter runs free from reset
   // internal mode counts at the last phase of each cycle
   // pin mode counts an edge only at the second or fourth phase
   // the pin passes three flops before it is looked at
   // so a pin edge shows in the count four to five clocks late
   // pin pulses shorter than three phases may be lost
   // a count write wins over an increment in the same clock
   // a hardware set wins over a software clear in one clock
   // the watchdog counter here is a small stand-in
   // its width is a parameter, not a documented figure
   // sleep stops the timer only, never the watchdog

   // ----------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------
   logic [7:0] count_value_reg;
   logic [7:0] option_control_reg;
   logic [7:0] interrupt_control_reg;
   logic [7:0] port_a_direction_reg;
   logic [1:0] irq_stat_reg;
   logic [1:0] irq_en_reg;
   logic [7:0] rdata_reg;
   logic       irq_reg;
   logic [1:0] qphase_reg;
   logic [2:0] pin_sync_reg;
   logic       pin_level_reg;
   logic [1:0] inhibit_reg;
   logic [WDT_WIDTH-1:0] wdt_reg;
   logic       wdt_to_reg;

   // ----------------------------------------------------------
   // decode
   // ----------------------------------------------------------
   wire wr_count  = bus.wr && (bus.addr == `TMZ_OFF_COUNT);
   wire wr_intctl = bus.wr && (bus.addr == `TMZ_OFF_INTCTL);
   wire wr_option = bus.wr && (bus.addr == `TMZ_OFF_OPTION);
   wire wr_porta  = bus.wr && (bus.addr == `TMZ_OFF_PORTA_DIR);
   wire wr_irq_en = bus.wr && (bus.addr == `TMZ_OFF_IRQ_EN);
   wire wr_irq_cl = bus.wr && (bus.addr == `TMZ_OFF_IRQ_CLR);

   wire        clk_src   = option_control_reg[`TMZ_OPT_CS];
   wire        src_edge  = option_control_reg[`TMZ_OPT_SE];
   wire [2:0]  rate_select = option_control_reg[2:0];
   wire tmz_owner_t owner = option_control_reg[`TMZ_OPT_PSA] ? TMZ_OWNER_WDT : TMZ_OWNER_TIMER;

   // ----------------------------------------------------------
   // pin synchroniser and phase sampling
   // ----------------------------------------------------------
   // one instruction cycle ends at phase 3 (Q4)
   wire instr_tick = (qphase_reg == 2'(`TMZ_QPHASES - 1));
   // sample settled pin level only at Q2 and Q4
   wire q2_or_q4   = qphase_reg[0];
   wire pin_agree  = (pin_sync_reg[1] == pin_sync_reg[2]);
   wire pin_new    = pin_sync_reg[2];
   wire sample_now = q2_or_q4 && pin_agree;
   wire pin_event  = sample_now && (pin_new != pin_level_reg) &&
                     (src_edge ? !pin_new : pin_new);
   wire src_event  = clk_src ? pin_event : instr_tick;

   // ----------------------------------------------------------
   // shared divider
   // ----------------------------------------------------------
   wire div_out;
   // count write clears divider when owned by timer
   // watchdog clear clears divider when owned by watchdog
   wire div_clear = (owner == TMZ_OWNER_TIMER) ? wr_count : watchdog_clear_instruction;
   // timer uses raw events, watchdog gets the divider
   wire div_tick  = (owner == TMZ_OWNER_TIMER) ? (src_event && !sleep_mode) : instr_tick;

   // divider notes:
   // the option write does not clear the divider
   // so a rate change may give one short first period
   // software hides this by the documented switch order
   // the timer path is gated by sleep before the divider
   // the watchdog path ticks once per instruction cycle
   // single divide counter, never exposed to the bus
   tmz_divider #(.WIDTH(8)) u_div (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .clear     (div_clear),
      .tick      (div_tick),
      .rate      (rate_select),
      .owner     (owner),
      .out_pulse (div_out)
   );

   // ----------------------------------------------------------
   // count path
   // ----------------------------------------------------------
   wire timer_event = (owner == TMZ_OWNER_TIMER) ? div_out : src_event;
   // two-cycle inhibit after a count write
   wire do_inc      = timer_event && !sleep_mode && (inhibit_reg == 2'd0) && !wr_count;
   wire overflow    = do_inc && (count_value_reg == 8'hff);
   wire wdt_tick    = (owner == TMZ_OWNER_WDT) ? div_out : instr_tick;
   wire wdt_full    = &wdt_reg;

   wire [7:0] count_value_next = wr_count ? bus.wdata :
                                 (do_inc ? count_value_reg + 8'h01 : count_value_reg);
   wire [1:0] inhibit_next = wr_count ? 2'(`TMZ_INHIBIT_CYC) :
                             ((instr_tick && inhibit_reg != 2'd0) ? inhibit_reg - 2'd1 : inhibit_reg);

   // flag set wins over a software clear in the same cycle
   wire [7:0] intctl_wr_val = wr_intctl ? bus.wdata : interrupt_control_reg;
   wire [7:0] interrupt_control_next = intctl_wr_val | (overflow ? 8'h04 : 8'h00);

   wire [1:0] irq_events = {wdt_tick && wdt_full, overflow};
   wire [1:0] irq_stat_next = (irq_stat_reg & ~(wr_irq_cl ? bus.wdata[1:0] : 2'b00)) | irq_events;
   wire       ovf_pending = interrupt_control_next[`TMZ_INT_OVF_FLAG] &&
                            interrupt_control_next[`TMZ_INT_OVF_EN];
   wire       irq_next = ovf_pending || |(irq_stat_next & irq_en_reg);

   // divider is absent from the read map
   logic [7:0] rd_mux;
   always_comb begin
      case (bus.addr)
         `TMZ_OFF_COUNT:     rd_mux = count_value_reg;
         `TMZ_OFF_INTCTL:    rd_mux = interrupt_control_reg;
         `TMZ_OFF_OPTION:    rd_mux = option_control_reg;
         `TMZ_OFF_PORTA_DIR: rd_mux = port_a_direction_reg;
         `TMZ_OFF_WDT_STAT:  rd_mux = {7'h00, wdt_to_reg};
         `TMZ_OFF_IRQ_STAT:  rd_mux = {6'h00, irq_stat_reg};
         `TMZ_OFF_IRQ_EN:    rd_mux = {6'h00, irq_en_reg};
         default:            rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------
   // clocked state
   // ----------------------------------------------------------
   // phase counter and pin synchroniser
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         qphase_reg    <= 2'd0;
         pin_sync_reg  <= 3'b000;
         pin_level_reg <= 1'b0;
      end else begin
         qphase_reg    <= qphase_reg + 2'd1;
         pin_sync_reg  <= {pin_sync_reg[1:0], external_count_pin};
         if (sample_now) begin
            pin_level_reg <= pin_new;
         end
      end
   end

   // software registers and counter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_value_reg       <= 8'h00;
         option_control_reg    <= `TMZ_OPTION_RST;
         interrupt_control_reg <= `TMZ_INTCTL_RST;
         port_a_direction_reg  <= `TMZ_PORTA_RST;
         irq_en_reg            <= 2'b00;
         irq_stat_reg          <= 2'b00;
         inhibit_reg           <= 2'd0;
      end else begin
         count_value_reg       <= count_value_next;
         interrupt_control_reg <= interrupt_control_next;
         irq_stat_reg          <= irq_stat_next;
         inhibit_reg           <= inhibit_next;
         if (wr_option) begin
            option_control_reg <= bus.wdata;
         end
         if (wr_porta) begin
            port_a_direction_reg <= bus.wdata;
         end
         if (wr_irq_en) begin
            irq_en_reg <= bus.wdata[1:0];
         end
      end
   end

   // watchdog counter, cleared by its clear instruction
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wdt_reg    <= '0;
         wdt_to_reg <= 1'b0;
      end else if (watchdog_clear_instruction) begin
         wdt_reg    <= '0;
         wdt_to_reg <= 1'b0;
      end else if (wdt_tick) begin
         wdt_reg    <= wdt_reg + 1'b1;
         wdt_to_reg <= wdt_to_reg | wdt_full;
      end
   end

   // ----------------------------------------------------------
   // output notes
   // ----------------------------------------------------------
   // every top output leaves straight from a flop
   // read data are zero outside the cycle after a read
   // so software sees no stale value on an idle bus
   // the interrupt is a level, high while any cause stands
   // causes: overflow flag with its enable,
   // or any enabled sticky status bit
   // the timeout level drops only on a watchdog clear
   // trade-off: one clock of latency on the read data

   // registered outputs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= 8'h00;
         irq_reg   <= 1'b0;
      end else begin
         rdata_reg <= bus.rd ? rd_mux : 8'h00;
         irq_reg   <= irq_next;
      end
   end

   assign rdata            = rdata_reg;
   assign irq              = irq_reg;
   assign watchdog_timeout = wdt_to_reg;
endmodule

// *** tmz_timer0_checker.sv ***
// concurrent checks on the ports of the timer/counter
`timescale 1ns/1ps
module tmz_timer0_checker
   import tmz_pkg::*;
#(
   parameter int WDT_WIDTH = 8
) (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       external_count_pin,
   input wire logic       sleep_mode,
   input wire logic       watchdog_clear_instruction,
   input wire logic       watchdog_timeout,
   input wire logic       irq
);
   logic [3:0] slp_cnt_reg;
   // run length of sleep, saturating so long sleeps stay valid
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) slp_cnt_reg <= 4'h0;
      else if (!sleep_mode) slp_cnt_reg <= 4'h0;
      else if (slp_cnt_reg != 4'hf) slp_cnt_reg <= slp_cnt_reg + 4'h1;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // write followed at once by a read of the same place
   sequence s_wr_rd(a);
      wr && addr == a ##1 rd && addr == a;
   endsequence
   // two count reads two cycles apart, no write between, long in sleep
   sequence s_two_reads;
      slp_cnt_reg == 4'hf && rd && addr == 8'h01 && $past(rd, 2) && $past(addr, 2) == 8'h01 && !$past(wr);
   endsequence
   a_option_write_back: assert property (s_wr_rd(8'h81) |=> rdata == $past(wdata, 2))
      else $error("option readback differs");
   a_dir_write_back: assert property (s_wr_rd(8'h85) |=> rdata == $past(wdata, 2))
      else $error("direction readback differs");
   a_count_write_hold: assert property (s_wr_rd(8'h01) |=> rdata == $past(wdata, 2))
      else $error("count moved right after write");
   a_unmapped_reads_zero: assert property (rd && addr == 8'h40 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_clear_reads_zero: assert property (rd && addr == 8'h93 |=> rdata == 8'h00)
      else $error("clear register read not zero");
   a_idle_rdata_zero: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data without read");
   a_wdt_clear_drop: assert property (watchdog_clear_instruction |-> ##[1:2] !watchdog_timeout)
      else $error("timeout kept after clear");
   a_sleep_count_hold: assert property (s_two_reads |=> rdata == $past(rdata, 2))
      else $error("count moved in sleep");
endmodule
bind tmz_timer0 tmz_timer0_checker #(.WDT_WIDTH(WDT_WIDTH)) u_chk (.mclk(mclk), .rst_b(rst_b), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_count_pin(external_count_pin),
   .sleep_mode(sleep_mode), .watchdog_clear_instruction(watchdog_clear_instruction),
   .watchdog_timeout(watchdog_timeout), .irq(irq));

// *** tmz_timer0_tb_top.sv ***
// self-checking bench for the timer/counter with shared divider
`timescale 1ns/1ps
module tmz_timer0_tb_top;
   logic       mclk, rst_b, wr, rd, pin, slp, wdc, wto, irq;
   logic [7:0] addr, wdata, rdata, d, c0, c1, c2;
   int         failures = 0, checked = 0, cyc = 0, n;
   tmz_timer0 dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .external_count_pin(pin), .sleep_mode(slp), .watchdog_clear_instruction(wdc),
      .watchdog_timeout(wto), .irq(irq));
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // flags are looked at mid-cycle, clear of edge updates
   task automatic chk1(input string nm, input logic e, ref logic g);
      @(negedge mclk);
      checked++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
      @(posedge mclk);
   endtask
   task automatic idle(input int k);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (k) @(posedge mclk);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      rd <= 1'b0;
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
   endtask
   // read data are taken in the one cycle they stand
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      v = rdata;
      @(posedge mclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
      rd_reg(a, d);
      chk8(nm, e, d);
   endtask
   task automatic wclr();
      wdc <= 1'b1;
      idle(1);
      wdc <= 1'b0;
   endtask
   // reads spaced p cycles apart; the count gained is exact
   task automatic span(input int p, input int e, input string nm);
      rd_reg(8'h01, c0);
      idle(p - 2);
      rd_reg(8'h01, c1);
      chk8(nm, 8'(e), c1 - c0);
   endtask
   task automatic to_tmr(input logic [7:0] v);
      wclr();
      wr_reg(8'h81, v);
   endtask
   task automatic to_wdt(input int r);
      wclr();
      wr_reg(8'h01, 8'h00);
      if (r < 2) wr_reg(8'h81, 8'hcf);
      wr_reg(8'h81, 8'hc8 | 8'(r));
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // clock and hang guard
   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      {rst_b, wr, rd, pin, slp, wdc, addr, wdata} = '0;
      void'($urandom(32'h68fd));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      idle(2);
      rchk(8'h81, 8'hff, "option_rst");
      rchk(8'h01, 8'h00, "count_rst");
      rchk(8'h0b, 8'h00, "intctl_rst");
      wr_reg(8'h81, 8'hc8);
      rchk(8'h81, 8'hc8, "option");
      n = $urandom_range(255);
      wr_reg(8'h85, 8'(n));
      rchk(8'h85, 8'(n), "dir");
      rchk(8'h40, 8'h00, "unmapped");
      rchk(8'h93, 8'h00, "irq_clear");
      span(400, 100, "slope");
      slp <= 1'b1;
      idle(20);
      rd_reg(8'h01, c2);
      idle(200);
      rd_reg(8'h01, c0);
      rchk(8'h01, c2, "sleep");
      slp <= 1'b0;
      wr_reg(8'h01, 8'hf0);
      idle(120);
      rchk(8'h0b, 8'h04, "ovf_flag");
      chk1("irq_masked", 1'b0, irq);
      rd_reg(8'h91, d);
      chk8("ovf_sticky", 8'h01, d & 8'h01);
      wr_reg(8'h93, 8'h01);
      rd_reg(8'h91, d);
      chk8("ovf_cleared", 8'h00, d & 8'h01);
      wr_reg(8'h0b, 8'h20);
      idle(4);
      chk1("irq_clr", 1'b0, irq);
      wr_reg(8'h01, 8'hf0);
      idle(120);
      chk1("irq_set", 1'b1, irq);
      for (int r = 0; r < 8; r++) begin
         to_tmr(8'hc0 | 8'(r));
         span(24 << r, 3, "rate");
      end
      repeat (6) begin
         n = $urandom_range(255);
         wr_reg(8'h01, 8'(n));
         rchk(8'h01, 8'(n), "count_wr");
         idle(40);
         rchk(8'h01, 8'(n), "div_clear");
      end
      to_wdt(0);
      repeat (3) begin
         idle(600);
         wclr();
      end
      chk1("wdt_kept", 1'b0, wto);
      idle(1200);
      chk1("wdt_fire", 1'b1, wto);
      to_wdt(1);
      idle(1600);
      chk1("wdt_half", 1'b0, wto);
      idle(800);
      chk1("wdt_div2", 1'b1, wto);
      for (int se = 0; se < 2; se++) begin
         wr_reg(8'h81, se ? 8'hf8 : 8'he8);
         pin <= 1'b1;
         idle(32);
         rd_reg(8'h01, c0);
         pin <= 1'b0;
         idle(32);
         rd_reg(8'h01, c1);
         chk8("fall_edge", 8'(se), c1 - c0);
         pin <= 1'b1;
         idle(32);
         rd_reg(8'h01, c2);
         chk8("rise_edge", 8'(1 - se), c2 - c1);
         n = $urandom_range(8, 1);
         repeat (n) begin
            pin <= 1'b0;
            idle(16);
            pin <= 1'b1;
            idle(16);
         end
         rd_reg(8'h01, c0);
         chk8("pulses", 8'(n), c0 - c2);
      end
      finish_test();
   end
endmodule
